// >>> psp_pkg.sv
// shared constants and types of the pipelined burst memory port
`default_nettype none
package psp_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int PSP_LANES    = 4;
  localparam int PSP_LANE_W   = 9;
  localparam int PSP_WORD_W   = PSP_LANES * PSP_LANE_W;
  localparam int PSP_DQ_W     = 32;
  localparam int PSP_ADDR_W   = 19;
  localparam int PSP_BURST_W  = 2;
  localparam int PSP_FIFO_D   = 8;
  // ---------------------------------------------------------------
  // timing, in clock cycles
  // ---------------------------------------------------------------
  localparam int PSP_SLEEP_CYC = 2;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic PSP_RST_DRIVE = 1'b0;
  localparam logic PSP_RST_VALID = 1'b0;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {PSP_LINEAR, PSP_INTERLEAVED} psp_order_t;
  typedef enum logic [1:0] {PSP_AWAKE, PSP_ENTER, PSP_ASLEEP, PSP_LEAVE} psp_sleep_t;
endpackage
`default_nettype wire

// >>> psp_wr_if.sv
// write buffer handshake between the port core and its fifo
`default_nettype none
interface psp_wr_if #(parameter int W = 8);
  logic [W-1:0] inData;
  logic         inValid;
  logic         inReady;
  logic [W-1:0] outData;
  logic         outValid;
  logic         outReady;
  modport core (output inData, inValid, outReady, input inReady, outData, outValid);
  modport fifo (input inData, inValid, outReady, output inReady, outData, outValid);
endinterface
`default_nettype wire

// >>> psp_fifo.sv
// small synchronous fifo holding posted write words
`default_nettype none
module psp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // buffer ports
  psp_wr_if.fifo    wr
);
  localparam int PW = $clog2(D);
  logic [W-1:0] store [D];
  logic [PW-1:0] rdPtr;
  logic [PW-1:0] wrPtr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;

  assign push        = wr.inValid && wr.inReady;
  assign pop         = wr.outValid && wr.outReady;
  assign wr.inReady  = (count != (PW+1)'(D));
  assign wr.outValid = (count != '0);
  assign wr.outData  = store[rdPtr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wrPtr] <= wr.inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdPtr <= '0;
      wrPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == PW'(D-1)) ? '0 : PW'(wrPtr + 1'b1);
      end
      if (pop) begin
        rdPtr <= (rdPtr == PW'(D-1)) ? '0 : PW'(rdPtr + 1'b1);
      end
      count <= (PW+1)'(count + (PW+1)'(push) - (PW+1)'(pop));
    end
  end
endmodule
`default_nettype wire

// >>> psp_port.sv
// pipelined burst static memory port with late write and sleep
`default_nettype none
module psp_port
  import psp_pkg::*;
#(
  parameter int ADDR_W = psp_pkg::PSP_ADDR_W
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  // synchronous control
  input  wire logic                        clockQualifierN,
  input  wire logic                        chipSelect1N,
  input  wire logic                        chipSelect2,
  input  wire logic                        chipSelect3N,
  input  wire logic                        advanceOrLoad,
  input  wire logic                        writeEnableN,
  input  wire logic [psp_pkg::PSP_LANES-1:0] byteLaneSelectN,
  input  wire logic [ADDR_W-1:0]           addr,
  // asynchronous control and strap
  input  wire logic                        outputEnableN,
  input  wire logic                        sleepRequest,
  input  wire logic                        burstOrder,
  // data and parity lines
  input  wire logic [psp_pkg::PSP_DQ_W-1:0]  dqIn,
  input  wire logic [psp_pkg::PSP_LANES-1:0] parityLinesIn,
  output logic      [psp_pkg::PSP_DQ_W-1:0]  dqOut,
  output logic      [psp_pkg::PSP_LANES-1:0] parityLinesOut,
  output logic                             dataOe
);
  import psp_pkg::*;
  localparam int FW = ADDR_W + PSP_LANES + PSP_WORD_W;
  // ---------------------------------------------------------------
  // asynchronous inputs
  // ---------------------------------------------------------------
  logic [1:0] oeSync;
  logic [1:0] sleepSync;
  logic [1:0] orderSync;
  logic       strapTaken;
  psp_order_t order;
  always_ff @(posedge clk_sys) begin
    oeSync    <= {oeSync[0], outputEnableN};
    sleepSync <= {sleepSync[0], sleepRequest};
    orderSync <= {orderSync[0], burstOrder};
  end

  // strap is caught once after reset; a floating pin is pulled high outside
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      strapTaken <= 1'b0;
      order      <= PSP_INTERLEAVED;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      order      <= orderSync[1] ? PSP_INTERLEAVED : PSP_LINEAR;
    end
  end

  // ---------------------------------------------------------------
  // sleep sequencing
  // ---------------------------------------------------------------
  psp_sleep_t sleepState;
  logic [1:0] sleepCnt;
  logic       awake;
  assign awake = (sleepState == PSP_AWAKE);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sleepState <= PSP_AWAKE;
      sleepCnt   <= '0;
    end else begin
      unique case (sleepState)
        PSP_AWAKE: begin
          sleepCnt <= '0;
          if (sleepSync[1]) begin
            sleepState <= PSP_ENTER;
          end
        end
        PSP_ENTER: begin
          sleepCnt <= 2'(sleepCnt + 1'b1);
          if (sleepCnt == 2'(PSP_SLEEP_CYC - 1)) begin
            sleepState <= PSP_ASLEEP;
          end
        end
        PSP_ASLEEP: begin
          sleepCnt <= '0;
          if (!sleepSync[1]) begin
            sleepState <= PSP_LEAVE;
          end
        end
        PSP_LEAVE: begin
          sleepCnt <= 2'(sleepCnt + 1'b1);
          if (sleepCnt == 2'(PSP_SLEEP_CYC - 1)) begin
            sleepState <= PSP_AWAKE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write buffer
  // ---------------------------------------------------------------
  psp_wr_if #(.W(FW)) wrIf ();
  psp_fifo #(.W(FW), .D(PSP_FIFO_D)) u_fifo (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wr      (wrIf.fifo)
  );

  // a full buffer stalls the port just as the qualifier does
  logic en;
  assign en = !clockQualifierN && wrIf.inReady && awake;

  // ---------------------------------------------------------------
  // command capture and burst counter
  // ---------------------------------------------------------------
  logic                  sel;
  logic                  burstValid;
  logic                  burstWrite;
  logic [ADDR_W-1:0]     burstBase;
  logic [PSP_BURST_W-1:0] burstStart;
  logic [PSP_BURST_W-1:0] burstCnt;
  logic [PSP_BURST_W-1:0] next_cnt;
  logic [PSP_BURST_W-1:0] next_low;
  logic                  s1Valid;
  logic                  s1Write;
  logic [ADDR_W-1:0]     s1Addr;
  logic [PSP_LANES-1:0]  s1Lanes;
  assign sel      = !chipSelect1N && chipSelect2 && !chipSelect3N;
  assign next_cnt = PSP_BURST_W'(burstCnt + 1'b1);
  assign next_low = (order == PSP_INTERLEAVED) ? (burstStart ^ next_cnt)
                                               : PSP_BURST_W'(burstStart + next_cnt);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      burstValid <= PSP_RST_VALID;
      burstWrite <= 1'b0;
      burstBase  <= '0;
      burstStart <= '0;
      burstCnt   <= '0;
      s1Valid    <= PSP_RST_VALID;
      s1Write    <= 1'b0;
      s1Addr     <= '0;
      s1Lanes    <= '0;
    end else if (!awake) begin
      // accesses pending at sleep entry are dropped
      burstValid <= 1'b0;
      s1Valid    <= 1'b0;
    end else if (en) begin
      s1Lanes <= ~byteLaneSelectN;
      if (!advanceOrLoad) begin
        burstValid <= sel;
        s1Valid    <= sel;
        if (sel) begin
          burstWrite <= !writeEnableN;
          s1Write    <= !writeEnableN;
          burstBase  <= addr;
          burstStart <= addr[PSP_BURST_W-1:0];
          burstCnt   <= '0;
          s1Addr     <= addr;
        end
      end else begin
        // continuation ignores selects and strobe
        burstCnt <= next_cnt;
        s1Valid  <= burstValid;
        s1Write  <= burstWrite;
        s1Addr   <= {burstBase[ADDR_W-1:PSP_BURST_W], next_low};
      end
    end
  end

  // ---------------------------------------------------------------
  // late write stage
  // ---------------------------------------------------------------
  logic                 s2Write;
  logic [ADDR_W-1:0]    s2Addr;
  logic [PSP_LANES-1:0] s2Lanes;
  logic [PSP_WORD_W-1:0] pinWord;
  always_ff @(posedge clk_sys) begin
    if (!nrst || !awake) begin
      s2Write <= 1'b0;
      s2Addr  <= '0;
      s2Lanes <= '0;
    end else if (en) begin
      s2Write <= s1Valid && s1Write;
      s2Addr  <= s1Addr;
      s2Lanes <= s1Lanes;
    end
  end

  // lane i carries its data byte and its parity bit
  for (genvar i = 0; i < PSP_LANES; i++) begin : g_lane
    assign pinWord[i*PSP_LANE_W +: PSP_LANE_W] = {parityLinesIn[i], dqIn[i*8 +: 8]};
  end

  // a write with no lane selected still floats the bus but posts nothing
  assign wrIf.inValid  = en && s2Write && (s2Lanes != '0);
  assign wrIf.inData   = {s2Addr, s2Lanes, pinWord};
  // draining stops with the qualifier so stalls freeze the whole pipe
  assign wrIf.outReady = !clockQualifierN;

  // ---------------------------------------------------------------
  // memory array
  // ---------------------------------------------------------------
  logic [PSP_WORD_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0]     headAddr;
  logic [PSP_LANES-1:0]  headLanes;
  logic [PSP_WORD_W-1:0] headWord;
  assign {headAddr, headLanes, headWord} = wrIf.outData;
  function automatic logic [PSP_WORD_W-1:0] merge(
    input logic [PSP_WORD_W-1:0] old,
    input logic [PSP_WORD_W-1:0] upd,
    input logic [PSP_LANES-1:0]  lanes
  );
    logic [PSP_WORD_W-1:0] res;
    res = old;
    for (int i = 0; i < PSP_LANES; i++) begin
      if (lanes[i]) begin
        res[i*PSP_LANE_W +: PSP_LANE_W] = upd[i*PSP_LANE_W +: PSP_LANE_W];
      end
    end
    return res;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (wrIf.outValid && wrIf.outReady) begin
      mem[headAddr] <= merge(mem[headAddr], headWord, headLanes);
    end
  end

  // reads see posted words not yet drained, oldest first
  logic [PSP_WORD_W-1:0] rdWord;
  always_comb begin
    rdWord = mem[s1Addr];
    if (wrIf.outValid && headAddr == s1Addr) begin
      rdWord = merge(rdWord, headWord, headLanes);
    end
    if (wrIf.inValid && s2Addr == s1Addr) begin
      rdWord = merge(rdWord, pinWord, s2Lanes);
    end
  end

  // ---------------------------------------------------------------
  // output register and driver control
  // ---------------------------------------------------------------
  logic driveRead;
  logic next_drive;
  assign next_drive = en ? (s1Valid && !s1Write) : driveRead;
  always_ff @(posedge clk_sys) begin
    if (!nrst || !awake) begin
      driveRead <= PSP_RST_DRIVE;
    end else begin
      driveRead <= next_drive;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dqOut          <= '0;
      parityLinesOut <= '0;
    end else if (en && s1Valid && !s1Write) begin
      for (int i = 0; i < PSP_LANES; i++) begin
        dqOut[i*8 +: 8]   <= rdWord[i*PSP_LANE_W +: 8];
        parityLinesOut[i] <= rdWord[i*PSP_LANE_W + 8];
      end
    end
  end

  // the synchronised enable is a registered level that changes only on edges, and dataOe follows it one edge later
  always_ff @(posedge clk_sys) begin
    if (!nrst || !awake) begin
      dataOe <= PSP_RST_DRIVE;
    end else begin
      dataOe <= next_drive && !oeSync[1];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_stall_hold;
    clockQualifierN |=> $stable(s1Addr) && $stable(burstCnt) && $stable(s2Write);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall changed state");
  property p_read_drive;
    (en && s1Valid && !s1Write && !oeSync[1]) |=> dataOe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");
  property p_oe_gate;
    dataOe |-> $past(!oeSync[1]);
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("driving with enable high");
  property p_deselect;
    (en && !s1Valid) |=> !dataOe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect did not float");
  property p_write_float;
    (en && s1Valid && s1Write) |=> !dataOe;
  endproperty
  a_write_float: assert property (p_write_float) else $error("write cycle driven");
  property p_linear;
    (en && advanceOrLoad && order == PSP_LINEAR)
      |=> s1Addr[1:0] == 2'($past(s1Addr[1:0]) + 1'b1);
  endproperty
  a_linear: assert property (p_linear) else $error("linear step wrong");
  property p_interleave;
    (en && advanceOrLoad && order == PSP_INTERLEAVED)
      |=> s1Addr[1:0] == ($past(burstStart) ^ 2'($past(burstCnt) + 1'b1));
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave wrong");
  property p_dir_hold;
    (en && advanceOrLoad) |=> $stable(burstWrite) && s1Write == burstWrite;
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed");
  property p_late_data;
    (en && s1Valid && s1Write && s1Lanes != '0) ##1 en |-> wrIf.inValid;
  endproperty
  a_late_data: assert property (p_late_data) else $error("write data not taken");
  property p_sleep_float;
    (sleepState == PSP_ASLEEP) |-> !dataOe && !s1Valid;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("active in sleep");
  // entry state is held for two edges, asleep is seen on the third
  property p_sleep_entry;
    (awake && sleepSync[1]) |=> !awake ##2 (sleepState == PSP_ASLEEP);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry late");
  property p_reset;
    @(posedge clk_sys) disable iff (1'b0) !nrst |=> !dataOe;
  endproperty
  a_reset: assert property (p_reset) else $error("drive after reset");
  c_read: cover property (en && s1Valid && !s1Write ##1 dataOe);
  c_write: cover property (wrIf.inValid && s2Lanes != '1);
  c_burst: cover property (en && advanceOrLoad && burstValid && burstCnt == 2'(2));
  c_sleep: cover property (sleepState == PSP_LEAVE ##2 awake);
endmodule
`default_nettype wire

// >>> psp_host.sv
// host memory controller model driving the port's synchronous pins and data lines
`default_nettype none
module psp_host #(
  parameter int AW = 6
) (
  // clock
  input  wire logic                          clk_sys,
  // command pins
  output var logic                           clockQualifierN,
  output var logic                           chipSelect1N,
  output var logic                           chipSelect2,
  output var logic                           chipSelect3N,
  output var logic                           advanceOrLoad,
  output var logic                           writeEnableN,
  output var logic [psp_pkg::PSP_LANES-1:0]  byteLaneSelectN,
  output var logic [AW-1:0]                  addr,
  // shared data lines
  input  wire logic [psp_pkg::PSP_DQ_W-1:0]  dqOut,
  input  wire logic [psp_pkg::PSP_LANES-1:0] parityLinesOut,
  input  wire logic                          dataOe,
  output logic      [psp_pkg::PSP_DQ_W-1:0]  dqIn,
  output logic      [psp_pkg::PSP_LANES-1:0] parityLinesIn
);
  timeunit 1ns;
  timeprecision 1ns;
  import psp_pkg::*;
  logic [PSP_WORD_W-1:0] wdata = '0;
  logic [PSP_WORD_W-1:0] d1 = '0;
  logic [PSP_WORD_W-1:0] d2 = '0;
  logic [PSP_WORD_W-1:0] lastBus = '0;
  logic [PSP_WORD_W-1:0] bus;
  logic                  v1 = 1'b0;
  logic                  v2 = 1'b0;
  logic                  burstWr = 1'b0;
  logic                  sel;

  initial begin
    clockQualifierN = 1'b0;
    chipSelect1N = 1'b1;
    chipSelect2 = 1'b0;
    chipSelect3N = 1'b1;
    advanceOrLoad = 1'b0;
    writeEnableN = 1'b1;
    byteLaneSelectN = 4'hf;
    addr = '0;
  end

  // ---------------------------------------------------------------
  // write data pipeline
  // ---------------------------------------------------------------
  assign sel = !chipSelect1N && chipSelect2 && !chipSelect3N;
  // data follows its command by two qualified edges, so stalls hold it back
  always @(posedge clk_sys) begin
    if (!clockQualifierN) begin
      if (!advanceOrLoad) begin
        burstWr <= sel && !writeEnableN;
      end
      v1 <= advanceOrLoad ? burstWr : (sel && !writeEnableN);
      d1 <= wdata;
      v2 <= v1;
      d2 <= d1;
    end
    lastBus <= bus;
  end
  // a released bus shows the inverse of its last level, never a stale copy
  assign bus = v2 ? d2 : (dataOe ? {parityLinesOut, dqOut} : ~lastBus);
  assign dqIn = bus[PSP_DQ_W-1:0];
  assign parityLinesIn = bus[PSP_WORD_W-1:PSP_DQ_W];

  // ---------------------------------------------------------------
  // one command: 0 deselect, 1 read, 2 write, 3 continue, 4 stalled write
  // ---------------------------------------------------------------
  task automatic op(input logic [2:0] k, input logic [AW-1:0] a, input logic [3:0] ln,
                    input logic [PSP_WORD_W-1:0] d);
    @(negedge clk_sys);
    clockQualifierN = (k == 3'd4);
    advanceOrLoad = (k == 3'd3);
    {chipSelect1N, chipSelect2, chipSelect3N} = (k == 3'd1 || k == 3'd2 || k == 3'd4) ?
                                                3'h2 : 3'h5;
    writeEnableN = !(k == 3'd2 || k == 3'd3 || k == 3'd4);
    byteLaneSelectN = ln;
    addr = a;
    wdata = d;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> psp_port_bench.sv
// self-checking bench of the pipelined burst memory port
`default_nettype none
module psp_port_bench
  import psp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 6;
  localparam int LIMIT = 2000;
  localparam logic [35:0] BASE = 36'h5_aabbccdd;
  localparam logic [35:0] UPD = 36'ha_01234567;
  localparam logic [35:0] DW = 36'h6_12345600;
  // address, active-low lanes of the second write, word read back
  localparam logic [45:0] ROWS [4] = '{{6'h01, 4'he, 36'h4_aabbcc67},
                                       {6'h02, 4'h5, 36'hf_01bb45dd},
                                       {6'h03, 4'h0, 36'ha_01234567},
                                       {6'h04, 4'hf, 36'h5_aabbccdd}};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic outputEnableN = 1'b0;
  logic sleepRequest = 1'b0;
  logic burstOrder = 1'b0;
  logic cqN, cs1N, cs2, cs3N, adv, weN, oe;
  logic [3:0]    lanesN, parIn, parOut;
  logic [AW-1:0] addr;
  logic [31:0]   dqIn, dqOut;
  logic [35:0]   rdWord;
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  assign rdWord = {parOut, dqOut};
  always #25 clk_sys = ~clk_sys;

  psp_port #(.ADDR_W(AW)) i_psp_port (
    .clk_sys(clk_sys), .nrst(nrst), .clockQualifierN(cqN), .chipSelect1N(cs1N),
    .chipSelect2(cs2), .chipSelect3N(cs3N), .advanceOrLoad(adv), .writeEnableN(weN),
    .byteLaneSelectN(lanesN), .addr(addr), .outputEnableN(outputEnableN),
    .sleepRequest(sleepRequest), .burstOrder(burstOrder), .dqIn(dqIn),
    .parityLinesIn(parIn), .dqOut(dqOut), .parityLinesOut(parOut), .dataOe(oe));

  psp_host #(.AW(AW)) i_psp_host (
    .clk_sys(clk_sys), .clockQualifierN(cqN), .chipSelect1N(cs1N), .chipSelect2(cs2),
    .chipSelect3N(cs3N), .advanceOrLoad(adv), .writeEnableN(weN), .byteLaneSelectN(lanesN),
    .addr(addr), .dqOut(dqOut), .parityLinesOut(parOut), .dataOe(oe), .dqIn(dqIn),
    .parityLinesIn(parIn));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      finish_test();
    end
  end

  task automatic rst(input logic m);
    @(negedge clk_sys);
    burstOrder = m;
    nrst = 1'b0;
    repeat (16) @(negedge clk_sys);
    chk({rdWord, 35'h0} >> 35, 36'h0);
    chk({35'h0, oe}, 36'h0);
    nrst = 1'b1;
    @(negedge clk_sys);
  endtask

  task automatic rdchk(input logic [AW-1:0] a, input logic [35:0] e);
    i_psp_host.op(3'd1, a, 4'hf, '0);
    i_psp_host.op(3'd0, a, 4'hf, '0);
    #1 chk(rdWord, e);
  endtask

  function automatic logic [1:0] ord(input logic m, input logic [1:0] s, input logic [1:0] i);
    return m ? (s ^ i) : (s + i);
  endfunction

  // burst write from low bits 1, burst read from low bits 2 with selects and strobe wrong
  task automatic burst(input logic m);
    logic [35:0] mem [4];
    for (int i = 0; i < 4; i++) begin
      mem[ord(m, 2'd1, 2'(i))] = DW + 36'(i);
      i_psp_host.op((i == 0) ? 3'd2 : 3'd3, 6'h09, 4'h0, DW + 36'(i));
    end
    i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    i_psp_host.op(3'd1, 6'h0a, 4'hf, '0);
    for (int j = 0; j < 4; j++) begin
      i_psp_host.op((j < 3) ? 3'd3 : 3'd0, 6'h00, 4'h0, '0);
      #1 chk(rdWord, mem[ord(m, 2'd2, 2'(j))]);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst(1'b0);
    for (int r = 0; r < 4; r++) begin
      i_psp_host.op(3'd2, ROWS[r][45:40], 4'h0, BASE);
      i_psp_host.op(3'd2, ROWS[r][45:40], ROWS[r][39:36], UPD);
      rdchk(ROWS[r][45:40], ROWS[r][35:0]);
    end
    // stalled edges hold the output and drop the write presented meanwhile
    i_psp_host.op(3'd1, 6'h01, 4'hf, '0);
    i_psp_host.op(3'd1, 6'h02, 4'hf, '0);
    #1 chk(rdWord, ROWS[0][35:0]);
    repeat (3) begin
      i_psp_host.op(3'd4, 6'h04, 4'h0, '0);
      #1 chk(rdWord, ROWS[0][35:0]);
    end
    i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    #1 chk(rdWord, ROWS[1][35:0]);
    rdchk(6'h04, BASE);
    // deselect floats one edge late
    i_psp_host.op(3'd1, 6'h03, 4'hf, '0);
    i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    #1 chk({35'h0, oe}, 36'h1);
    i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    #1 chk({35'h0, oe}, 36'h0);
    // write right after a read floats the bus, even with no lanes
    i_psp_host.op(3'd1, 6'h03, 4'hf, '0);
    i_psp_host.op(3'd2, 6'h05, 4'hf, '0);
    #1 chk({35'h0, oe}, 36'h1);
    i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    #1 chk({35'h0, oe}, 36'h0);
    // output enable high keeps the drivers off
    @(negedge clk_sys) outputEnableN = 1'b1;
    repeat (4) i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    i_psp_host.op(3'd1, 6'h03, 4'hf, '0);
    i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    #1 chk({35'h0, oe}, 36'h0);
    @(negedge clk_sys) outputEnableN = 1'b0;
    repeat (4) i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    // sleep entered deselected, recovery kept deselected
    @(negedge clk_sys) sleepRequest = 1'b1;
    repeat (10) i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    #1 chk({35'h0, oe}, 36'h0);
    @(negedge clk_sys) sleepRequest = 1'b0;
    repeat (10) i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    rdchk(6'h03, UPD);
    burst(1'b0);
    i_psp_host.op(3'd0, 6'h00, 4'hf, '0);
    rst(1'b1);
    burst(1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
